// ===== verilog/rsq_sequencer.sv
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
// Operation
// R1 - slow-clock paced; drives cpu, backup, peripheral resets and reset pin
// R2 - reset pin resampled on slow clock; low level reports user reset
// R3 - pin_reset_enable low blocks user reset, high allows it
// R4 - pin falling edge sets sticky pin_fall_seen; status read clears
// R5 - irq when fall seen, irq enabled, pin reset disabled
// R6 - pin pulse lasts 2^(exponent+1) slow ticks
// R7 - boot select latched three slow ticks after core supply rises
// R8 - cause updated at cpu reset release; read leaves it
// R9 - general reset: startup count, 3 ticks held, release, pin pulse
// R10 - backup supply low asserts every reset at once
// R11 - core supply low asserts all but backup; 3 ticks on recovery
// R12 - user reset holds cpu and peripherals, then 2+3 ticks, cause 4
// R13 - external hold on pin keeps internal resets asserted
// R14 - each command bit honoured independently
// R15 - software reset asserts at once, lasts 3 slow ticks
// R16 - self-generated pin pulse never starts a user reset
// R17 - software cause recorded only with cpu command bit
// R18 - busy set on command, cleared at end; writes meanwhile ignored
// R19 - watchdog reset 3 ticks; cpu-only selects reset set and pulse
// R20 - watchdog faults ignored when watchdog reset disabled
// R21 - priority backup, wake, watchdog, software, user
// R22 - pin level bit sampled every master clock edge
module rsq_sequencer
  import rsq_pkg::*;
#(
  parameter logic [15:0] STARTUP_TICKS = RSQ_STARTUP_TICKS_DFLT
) (
  input wire logic mclk_i,              // master clock, 125 MHz
  input wire logic sys_rst_i,           // synchronous reset, high
  input wire logic clk_en_i,            // freezes all state when low
  input wire logic slow_clk_i,          // slow clock, sampled as a pin
  input wire logic backup_supply_ok_i,  // backup POR cell, high = good
  input wire logic core_supply_ok_i,    // core POR cell, high = good
  input wire logic wdog_fault_i,        // watchdog fault level
  input wire logic wdog_reset_enable_i, // watchdog may cause resets
  input wire logic wdog_cpu_only_i,     // watchdog resets cpu only
  input wire logic boot_select_pin_i,   // boot select strap pin
  input wire logic rst_pin_i,           // reset pin level
  input wire logic [7:0] addr_i,        // register byte address
  input wire logic [31:0] wdata_i,      // write data
  input wire logic wr_i,                // write strobe
  input wire logic rd_i,                // read strobe
  output logic [31:0] rdata_o,          // read data, cycle after rd_i
  output logic proc_rst_n_o,            // cpu and watchdog reset, low
  output logic backup_rst_n_o,          // backup domain reset, low
  output logic periph_rst_n_o,          // peripheral reset, low
  output logic rst_pin_o,               // reset pin output value (0)
  output logic rst_pin_oe_n_o,          // reset pin drive enable, low
  output logic cpu_clk_en_o,            // processor clock runs
  output logic boot_select_o,           // latched boot selection
  output logic irq_o                    // pin event interrupt
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic slow_s1, slow_s2, slow_s3;
  logic pin_s1, pin_s2, pin_s3;
  logic bkp_s1, bkp_s2;
  logic core_s1, core_s2, core_s3;
  logic wd_s1, wd_s2, wd_s3;
  logic bsel_s1, bsel_s2;
  logic tick;
  logic wd_evt;
  logic pin_fall;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      {slow_s1, slow_s2, slow_s3} <= 3'h0;
      {pin_s1, pin_s2, pin_s3} <= 3'h7;
      {bkp_s1, bkp_s2} <= 2'h0;
      {core_s1, core_s2, core_s3} <= 3'h0;
      {wd_s1, wd_s2, wd_s3} <= 3'h0;
      {bsel_s1, bsel_s2} <= 2'h0;
    end else if (clk_en_i) begin
      {slow_s1, slow_s2, slow_s3} <= {slow_clk_i, slow_s1, slow_s2};
      {pin_s1, pin_s2, pin_s3} <= {rst_pin_i, pin_s1, pin_s2};
      {bkp_s1, bkp_s2} <= {backup_supply_ok_i, bkp_s1};
      {core_s1, core_s2, core_s3} <= {core_supply_ok_i, core_s1, core_s2};
      {wd_s1, wd_s2, wd_s3} <= {wdog_fault_i, wd_s1, wd_s2};
      {bsel_s1, bsel_s2} <= {boot_select_pin_i, bsel_s1};
    end
  end

  assign tick = slow_s2 & ~slow_s3;
  // R20 watchdog gate
  assign wd_evt = wd_s2 & ~wd_s3 & wdog_reset_enable_i;
  assign pin_fall = pin_s3 & ~pin_s2;

  // ---------------------------------------------------------------
  // register state and command decode
  // ---------------------------------------------------------------
  rsq_state_t state;
  rsq_mode_t mode;
  logic [2:0] cause, cause_pend;
  logic pend_valid, hold_bkp;
  logic busy, soft_cpu, soft_per, wd_cpu;
  logic pin_fall_seen, next_fall_seen;
  logic pin_slow1, pin_slow2, pin_drive, pin_guard, pin_req;
  logic [16:0] pcnt;
  logic [15:0] cnt;
  logic [1:0] bcnt;
  logic cmd_wr, sr_read, key_ok, user_low;
  rsq_rst_t next_rst;

  assign key_ok = wdata_i[RSQ_KEY_LSB +: 8] == RSQ_KEY;
  assign sr_read = rd_i && addr_i == RSQ_OFS_STATUS;
  // R18 writes ignored while busy
  assign cmd_wr = wr_i && addr_i == RSQ_OFS_CMD && key_ok && !busy &&
                  state == RSQ_ST_RUN &&
                  (wdata_i[RSQ_CMD_CPU_BIT] || wdata_i[RSQ_CMD_PERIPH_BIT] ||
                   wdata_i[RSQ_CMD_PIN_BIT]);
  // R3 R16 user trigger gating
  assign user_low = !pin_slow2 && mode.pin_en && !pin_guard && !pin_drive;

  // mode register lives in the backup domain: only a backup loss clears it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode <= RSQ_MODE_RST;
    end else if (clk_en_i) begin
      if (!bkp_s2) begin
        mode <= RSQ_MODE_RST;
      end else if (wr_i && addr_i == RSQ_OFS_MODE && key_ok) begin
        mode.pin_en <= wdata_i[RSQ_MR_PIN_EN_BIT];
        mode.irq_en <= wdata_i[RSQ_MR_IRQ_EN_BIT];
        mode.exp <= wdata_i[RSQ_MR_EXP_LSB +: 4];
      end
    end
  end

  // ---------------------------------------------------------------
  // reset state manager
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= RSQ_ST_BACKUP;
      cnt <= STARTUP_TICKS;
      cause <= RSQ_CAUSE_RST;
      cause_pend <= RSQ_CAUSE_RST;
      pend_valid <= 1'b0;
      hold_bkp <= 1'b1;
      busy <= 1'b0;
      soft_cpu <= 1'b0;
      soft_per <= 1'b0;
      wd_cpu <= 1'b0;
      pin_req <= 1'b0;
    end else if (clk_en_i) begin
      pin_req <= 1'b0;
      // R10 R21 backup loss overrides everything
      if (!bkp_s2) begin
        state <= RSQ_ST_BACKUP;
        cnt <= STARTUP_TICKS;
        hold_bkp <= 1'b1;
        busy <= 1'b0;
      // R11 core loss, all but backup
      end else if (!core_s2 && state != RSQ_ST_BACKUP) begin
        state <= RSQ_ST_CORE_OFF;
        busy <= 1'b0;
      end else begin
        case (state)
          RSQ_ST_BACKUP: begin
            // R9 startup count then processor start
            if (tick) begin
              if (cnt == 16'h0000) begin
                state <= RSQ_ST_START;
                cnt <= RSQ_CPU_START_TICKS;
                cause_pend <= RSQ_CAUSE_GENERAL;
                pend_valid <= 1'b1;
              end else begin
                cnt <= cnt - 16'h0001;
              end
            end
          end
          RSQ_ST_CORE_OFF: begin
            state <= RSQ_ST_START;
            cnt <= RSQ_CPU_START_TICKS;
            cause_pend <= RSQ_CAUSE_WAKE;
            pend_valid <= 1'b1;
            hold_bkp <= 1'b0;
          end
          RSQ_ST_START: begin
            if (tick) begin
              if (cnt == 16'h0001) begin
                state <= RSQ_ST_RUN;
                hold_bkp <= 1'b0;
                // R9 R11 pin pulse follows a power reset
                pin_req <= cause_pend != RSQ_CAUSE_USER;
              end else begin
                cnt <= cnt - 16'h0001;
              end
            end
          end
          RSQ_ST_RUN: begin
            // R21 watchdog over software over user
            if (wd_evt) begin
              state <= RSQ_ST_WDOG;
              cnt <= RSQ_WDOG_TICKS;
              wd_cpu <= wdog_cpu_only_i;
              cause_pend <= RSQ_CAUSE_WDOG;
              pend_valid <= 1'b1;
              // R19 pulse only for full watchdog reset
              pin_req <= !wdog_cpu_only_i;
            end else if (cmd_wr) begin
              state <= RSQ_ST_SOFT;
              cnt <= RSQ_SOFT_TICKS;
              busy <= 1'b1;
              // R14 independent command bits
              soft_cpu <= wdata_i[RSQ_CMD_CPU_BIT];
              soft_per <= wdata_i[RSQ_CMD_PERIPH_BIT];
              pin_req <= wdata_i[RSQ_CMD_PIN_BIT];
              cause_pend <= RSQ_CAUSE_SOFT;
              // R17 cause only with cpu bit
              pend_valid <= wdata_i[RSQ_CMD_CPU_BIT];
            end else if (user_low) begin
              // R2 R3 user reset entry
              state <= RSQ_ST_USER;
            end
          end
          RSQ_ST_USER: begin
            // R12 R13 wait for pin seen high after resync
            if (pin_slow2) begin
              state <= RSQ_ST_START;
              cnt <= RSQ_CPU_START_TICKS;
              cause_pend <= RSQ_CAUSE_USER;
              pend_valid <= 1'b1;
            end
          end
          RSQ_ST_SOFT: begin
            // R21 watchdog preempts software; pin ignored
            if (wd_evt) begin
              state <= RSQ_ST_WDOG;
              cnt <= RSQ_WDOG_TICKS;
              wd_cpu <= wdog_cpu_only_i;
              cause_pend <= RSQ_CAUSE_WDOG;
              pend_valid <= 1'b1;
              pin_req <= !wdog_cpu_only_i;
              busy <= 1'b0;
            end else if (tick) begin
              // R15 R18 three ticks, then release
              if (cnt == 16'h0001) begin
                state <= RSQ_ST_RUN;
                busy <= 1'b0;
              end else begin
                cnt <= cnt - 16'h0001;
              end
            end
          end
          RSQ_ST_WDOG: begin
            // R19 three ticks
            if (tick) begin
              if (cnt == 16'h0001) begin
                state <= RSQ_ST_RUN;
              end else begin
                cnt <= cnt - 16'h0001;
              end
            end
          end
          default: begin
            state <= RSQ_ST_BACKUP;
            cnt <= STARTUP_TICKS;
          end
        endcase
      end
      // R8 cause loaded only when entering run
      if (state != RSQ_ST_RUN && state != RSQ_ST_BACKUP &&
          state != RSQ_ST_CORE_OFF && pend_valid && bkp_s2 && core_s2 &&
          ((state == RSQ_ST_START && tick && cnt == 16'h0001) ||
           (state == RSQ_ST_WDOG && tick && cnt == 16'h0001) ||
           (state == RSQ_ST_SOFT && !wd_evt && tick && cnt == 16'h0001))) begin
        cause <= cause_pend;
        pend_valid <= 1'b0;
      end
    end
  end

  // R1 reset set per state
  always_comb begin
    next_rst = '0;
    case (state)
      RSQ_ST_BACKUP: next_rst = '{proc: 1'b1, backup: 1'b1, periph: 1'b1};
      RSQ_ST_CORE_OFF: next_rst = '{proc: 1'b1, backup: 1'b0, periph: 1'b1};
      RSQ_ST_START: next_rst = '{proc: 1'b1, backup: hold_bkp, periph: 1'b1};
      RSQ_ST_USER: next_rst = '{proc: 1'b1, backup: 1'b0, periph: 1'b1};
      RSQ_ST_SOFT: next_rst = '{proc: soft_cpu, backup: 1'b0, periph: soft_per};
      RSQ_ST_WDOG: next_rst = '{proc: 1'b1, backup: 1'b0, periph: !wd_cpu};
      default: next_rst = '0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      proc_rst_n_o <= 1'b0;
      backup_rst_n_o <= 1'b0;
      periph_rst_n_o <= 1'b0;
      cpu_clk_en_o <= 1'b0;
    end else if (clk_en_i) begin
      proc_rst_n_o <= !next_rst.proc;
      backup_rst_n_o <= !next_rst.backup;
      periph_rst_n_o <= !next_rst.periph;
      cpu_clk_en_o <= state != RSQ_ST_BACKUP && state != RSQ_ST_CORE_OFF &&
                      state != RSQ_ST_USER;
    end
  end

  // ---------------------------------------------------------------
  // reset pin manager
  // ---------------------------------------------------------------
  // the guard masks our own pulse until the resynchronised pin is high
  // again, so the sampler lag cannot fake a user reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_slow1 <= 1'b1;
      pin_slow2 <= 1'b1;
      pin_drive <= 1'b0;
      pin_guard <= 1'b0;
      pcnt <= 17'h0_0000;
      rst_pin_o <= 1'b0;
      rst_pin_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_n_o <= !pin_drive;
      // R2 two-stage slow-clock resample
      if (tick) begin
        pin_slow1 <= pin_s2;
        pin_slow2 <= pin_slow1;
      end
      if (!bkp_s2) begin
        pin_drive <= 1'b0;
        pin_guard <= 1'b0;
      end else if (pin_req) begin
        // R6 pulse length from exponent
        pin_drive <= 1'b1;
        pin_guard <= 1'b1;
        pcnt <= 17'(17'h0_0001 << (5'(mode.exp) + 5'h01));
      end else if (pin_drive && tick) begin
        if (pcnt == 17'h0_0001) begin
          pin_drive <= 1'b0;
        end else begin
          pcnt <= pcnt - 17'h0_0001;
        end
      end else if (!pin_drive && pin_slow2 && pin_slow1) begin
        pin_guard <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // boot select capture
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bcnt <= 2'h0;
      boot_select_o <= 1'b0;
    end else if (clk_en_i) begin
      // R7 capture three ticks after core rise
      if (core_s2 && !core_s3) begin
        bcnt <= RSQ_BOOT_SAMPLE_TICKS;
      end else if (tick && bcnt != 2'h0) begin
        bcnt <= bcnt - 2'h1;
        if (bcnt == 2'h1) begin
          boot_select_o <= bsel_s2;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // status, interrupt and read port
  // ---------------------------------------------------------------
  // R4 set wins over the read clear
  assign next_fall_seen = pin_fall || (pin_fall_seen && !sr_read);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_fall_seen <= 1'b0;
      irq_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      pin_fall_seen <= next_fall_seen;
      // R5 interrupt only with pin reset disabled
      irq_o <= next_fall_seen && mode.irq_en && !mode.pin_en;
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        if (addr_i == RSQ_OFS_STATUS) begin
          rdata_o[RSQ_SR_FALL_BIT] <= pin_fall_seen;
          rdata_o[RSQ_SR_CAUSE_LSB +: 3] <= cause;
          // R22 level at master clock
          rdata_o[RSQ_SR_LEVEL_BIT] <= pin_s2;
          rdata_o[RSQ_SR_BUSY_BIT] <= busy;
        end else if (addr_i == RSQ_OFS_MODE) begin
          rdata_o[RSQ_MR_PIN_EN_BIT] <= mode.pin_en;
          rdata_o[RSQ_MR_IRQ_EN_BIT] <= mode.irq_en;
          rdata_o[RSQ_MR_EXP_LSB +: 4] <= mode.exp;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i || !clk_en_i);

  // a watchdog edge or supply loss in the same cycle takes priority
  sequence seq_cpu_cmd;
    cmd_wr && wdata_i[RSQ_CMD_CPU_BIT] && !wd_evt && bkp_s2 && core_s2;
  endsequence
  sequence seq_cpu_held;
    state == RSQ_ST_SOFT ##1 !proc_rst_n_o;
  endsequence

  AST_SOFT_ASSERT: assert property (seq_cpu_cmd |=> seq_cpu_held) // R15
    else $error("software cpu reset not asserted");
  AST_SOFT_BUSY: assert property ( // R18
    cmd_wr && !wd_evt && bkp_s2 && core_s2 |=> busy)
    else $error("busy not set on command");
  AST_WDOG_IGNORED: assert property ( // R20
    (wd_s2 && !wd_s3 && !wdog_reset_enable_i) |=> state != RSQ_ST_WDOG)
    else $error("disabled watchdog caused reset");
  AST_BACKUP_ALL: assert property ( // R10
    !bkp_s2 |-> ##2 (!proc_rst_n_o && !backup_rst_n_o && !periph_rst_n_o))
    else $error("backup loss did not assert all resets");
  AST_SOFT_NO_USER: assert property ( // R21
    state == RSQ_ST_SOFT && bkp_s2 && core_s2 |=> state != RSQ_ST_USER)
    else $error("user reset entered from software reset");
  AST_FALL_SET: assert property (pin_fall |=> pin_fall_seen) // R4
    else $error("pin fall not recorded");
  AST_CAUSE_AT_RELEASE: assert property ( // R8
    $changed(cause) |-> state == RSQ_ST_RUN && $past(state) != RSQ_ST_RUN)
    else $error("cause changed outside reset release");
  AST_IRQ: assert property ( // R5
    pin_fall_seen && !sr_read && mode.irq_en && !mode.pin_en |=> irq_o)
    else $error("interrupt missing");
  AST_PULSE: assert property ( // R6
    pin_req && bkp_s2 |=> pin_drive ##1 !rst_pin_oe_n_o)
    else $error("pin pulse not driven");

endmodule

// ===== verilog/rsq_pkg.sv
package rsq_pkg;

  // ---------------------------------------------------------------
  // register map and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] RSQ_OFS_CMD = 8'h00;
  localparam logic [7:0] RSQ_OFS_STATUS = 8'h04;
  localparam logic [7:0] RSQ_OFS_MODE = 8'h08;
  localparam logic [7:0] RSQ_KEY = 8'hA5;
  localparam int RSQ_KEY_LSB = 24;
  localparam int RSQ_CMD_CPU_BIT = 0;
  localparam int RSQ_CMD_PERIPH_BIT = 2;
  localparam int RSQ_CMD_PIN_BIT = 3;
  localparam int RSQ_SR_FALL_BIT = 0;
  localparam int RSQ_SR_CAUSE_LSB = 8;
  localparam int RSQ_SR_LEVEL_BIT = 16;
  localparam int RSQ_SR_BUSY_BIT = 17;
  localparam int RSQ_MR_PIN_EN_BIT = 0;
  localparam int RSQ_MR_IRQ_EN_BIT = 4;
  localparam int RSQ_MR_EXP_LSB = 8;

  // ---------------------------------------------------------------
  // cause codes, reset values, slow-clock counts
  // ---------------------------------------------------------------
  localparam logic [2:0] RSQ_CAUSE_GENERAL = 3'h0;
  localparam logic [2:0] RSQ_CAUSE_WAKE = 3'h1;
  localparam logic [2:0] RSQ_CAUSE_WDOG = 3'h2;
  localparam logic [2:0] RSQ_CAUSE_SOFT = 3'h3;
  localparam logic [2:0] RSQ_CAUSE_USER = 3'h4;
  localparam logic [2:0] RSQ_CAUSE_RST = RSQ_CAUSE_GENERAL;
  localparam logic [5:0] RSQ_MODE_RST = 6'h00;
  localparam logic [15:0] RSQ_STARTUP_TICKS_DFLT = 16'h0020;
  localparam logic [15:0] RSQ_CPU_START_TICKS = 16'h0003;
  localparam logic [15:0] RSQ_SOFT_TICKS = 16'h0003;
  localparam logic [15:0] RSQ_WDOG_TICKS = 16'h0003;
  localparam logic [1:0] RSQ_BOOT_SAMPLE_TICKS = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    RSQ_ST_BACKUP = 7'b000_0001,
    RSQ_ST_CORE_OFF = 7'b000_0010,
    RSQ_ST_START = 7'b000_0100,
    RSQ_ST_RUN = 7'b000_1000,
    RSQ_ST_USER = 7'b001_0000,
    RSQ_ST_SOFT = 7'b010_0000,
    RSQ_ST_WDOG = 7'b100_0000
  } rsq_state_t;

  typedef struct packed {
    logic proc;
    logic backup;
    logic periph;
  } rsq_rst_t;

  typedef struct packed {
    logic [3:0] exp;
    logic irq_en;
    logic pin_en;
  } rsq_mode_t;

endpackage

// ===== testbench/rsq_pin_partner.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// external device sharing the reset pin
// ---------------------------------------------------------------
module rsq_pin_partner (
  input wire logic oe_n_i, // sequencer drive enable, low = drive low
  input wire logic hold_i, // device holds the pin low
  output logic pin_o       // resolved wire level
);
  // external hold on wire
  // pull-up on the wire: a released pin reads high, never a stale value
  assign pin_o = !(oe_n_i === 1'b0 || hold_i === 1'b1);
endmodule

// ===== testbench/system_reset_sequencer_bench.sv
`timescale 1ns/100ps
module system_reset_sequencer_bench;
  import rsq_pkg::*;
  localparam int TK = 4;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic slow = 1'b0;
  logic [1:0] sdiv = 2'h0;
  logic bk_ok = 1'b1, core_ok = 1'b1, fault = 1'b0, wd_en = 1'b0;
  logic wd_cpu = 1'b0, boot = 1'b0, hold = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, d, rng;
  logic proc_n, bk_n, per_n, pin_o, oe_n, cclk, boot_o, irq, pin;
  int miscompares = 0;
  int comparisons = 0;
  int exp_cause, e, n;

  always #4 mclk_i = ~mclk_i;
  // slow clock at a quarter of the master rate: one tick every TK cycles
  always @(posedge mclk_i) begin
    sdiv <= sdiv + 2'h1;
    slow <= sdiv[1];
  end

  rsq_sequencer #(.STARTUP_TICKS(16'h0002)) DUT (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .slow_clk_i(slow), .backup_supply_ok_i(bk_ok),
    .core_supply_ok_i(core_ok), .wdog_fault_i(fault),
    .wdog_reset_enable_i(wd_en), .wdog_cpu_only_i(wd_cpu),
    .boot_select_pin_i(boot), .rst_pin_i(pin), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .proc_rst_n_o(proc_n), .backup_rst_n_o(bk_n), .periph_rst_n_o(per_n),
    .rst_pin_o(pin_o), .rst_pin_oe_n_o(oe_n), .cpu_clk_en_o(cclk),
    .boot_select_o(boot_o), .irq_o(irq));

  rsq_pin_partner partner (.oe_n_i(oe_n), .hold_i(hold), .pin_o(pin));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic sel(input int w);
    case (w)
      0: return proc_n;
      1: return per_n;
      2: return oe_n;
      default: return bk_n;
    endcase
  endfunction

  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge mclk_i);
  endtask

  // bounded wait for a reset output to reach a level
  task automatic wait_sig(input int w, input logic v);
    int k;
    k = 0;
    while (sel(w) !== v) begin
      @(posedge mclk_i);
      #1;
      k++;
      if (k > 3000) begin
        chk(sel(w), v);
        stop_test();
      end
    end
    // hand back on a rising edge so the caller drives on the edge
    @(posedge mclk_i);
  endtask

  task automatic chk_cause;
    repeat (60) @(posedge mclk_i);
    rd_reg(RSQ_OFS_STATUS);
    chk(d[10:8], exp_cause);
  endtask

  initial begin
    repeat (100000) @(posedge mclk_i);
    chk(32'h0000_0000, 32'h0000_0001);
    stop_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rng = xs(32'h0000_1974);
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    exp_cause = RSQ_CAUSE_GENERAL;
    wait_sig(0, 1'b1);
    chk(bk_n, 1'b1);
    chk(cclk, 1'b1);
    chk_cause();
    chk(d[16], 1'b1);
    wr_reg(RSQ_OFS_CMD, 32'hA500_0004);
    wait_sig(1, 1'b0);
    chk(proc_n, 1'b1);
    wait_sig(1, 1'b1);
    chk_cause();
    wr_reg(RSQ_OFS_CMD, 32'hA500_0001);
    wr_reg(RSQ_OFS_CMD, 32'hA500_0004);
    rd_reg(RSQ_OFS_STATUS);
    chk(d[17], 1'b1);
    wait_sig(0, 1'b0);
    chk(per_n, 1'b1);
    wait_sig(0, 1'b1);
    exp_cause = RSQ_CAUSE_SOFT;
    chk_cause();
    chk(d[17], 1'b0);
    e = int'(rng % 3);
    wr_reg(RSQ_OFS_MODE, 32'hA500_0001 | (e << 8));
    wr_reg(RSQ_OFS_CMD, 32'hA500_0008);
    wait_sig(2, 1'b0);
    chk(pin_o, 1'b0);
    n = 0;
    while (oe_n === 1'b0 && n < 9999) begin
      @(posedge mclk_i);
      n++;
    end
    chk(n >= (2 ** (e + 1) - 1) * TK && n <= (2 ** (e + 1) + 1) * TK, 1);
    chk_cause();
    wr_reg(RSQ_OFS_MODE, 32'hA500_0010);
    hold <= 1'b1;
    repeat (20) @(posedge mclk_i);
    chk(irq, 1'b1);
    chk(proc_n, 1'b1);
    rd_reg(RSQ_OFS_STATUS);
    chk(d[0], 1'b1);
    chk(d[16], 1'b0);
    repeat (2) @(posedge mclk_i);
    chk(irq, 1'b0);
    rd_reg(RSQ_OFS_STATUS);
    chk(d[0], 1'b0);
    hold <= 1'b0;
    repeat (20) @(posedge mclk_i);
    wr_reg(RSQ_OFS_MODE, 32'hA500_0001);
    hold <= 1'b1;
    wait_sig(0, 1'b0);
    repeat (100) @(posedge mclk_i);
    chk({proc_n, per_n}, 2'b00);
    chk(cclk, 1'b0);
    hold <= 1'b0;
    wait_sig(0, 1'b1);
    exp_cause = RSQ_CAUSE_USER;
    chk_cause();
    fault <= 1'b1;
    repeat (40) @(posedge mclk_i);
    fault <= 1'b0;
    repeat (40) @(posedge mclk_i);
    chk(proc_n, 1'b1);
    for (int c = 0; c < 2; c++) begin
      wd_cpu <= c[0];
      wd_en <= 1'b1;
      fault <= 1'b1;
      wait_sig(0, 1'b0);
      fault <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk(per_n, c[0]);
      wait_sig(0, 1'b1);
      exp_cause = RSQ_CAUSE_WDOG;
      chk_cause();
    end
    rng = xs(rng);
    core_ok <= 1'b0;
    wait_sig(0, 1'b0);
    chk(bk_n, 1'b1);
    boot <= rng[0];
    core_ok <= 1'b1;
    wait_sig(0, 1'b1);
    exp_cause = RSQ_CAUSE_WAKE;
    chk_cause();
    chk(boot_o, rng[0]);
    bk_ok <= 1'b0;
    wait_sig(3, 1'b0);
    chk({proc_n, per_n}, 2'b00);
    bk_ok <= 1'b1;
    wait_sig(0, 1'b1);
    exp_cause = RSQ_CAUSE_GENERAL;
    chk_cause();
    wr_reg(RSQ_OFS_MODE, 32'h5A00_0011);
    rd_reg(RSQ_OFS_MODE);
    chk(d, 32'h0000_0000);
    rd_reg(8'h0C);
    chk(d, 32'h0000_0000);
    stop_test();
  end
endmodule
